/* design/spsel_map.svh */
`ifndef SPSEL_MAP_SVH
`define SPSEL_MAP_SVH

// =====================================================================
// Register map
`define SPSEL_FUNC_OFFSET 12'h000
`define SPSEL_MEM_OFFSET 12'h004
`define SPSEL_LOOP_OFFSET 12'h008
`define SPSEL_REF_OFFSET 12'h00C
`define SPSEL_IRQ_OFFSET 12'h010
`define SPSEL_PIN_OFFSET 12'h014
`define SPSEL_FUNC_RESET 8'h80
`define SPSEL_TOP_BIT 7

// =====================================================================
// Function codes
`define SPSEL_C_LOW 8'h80
`define SPSEL_C_HIGH 8'h81
`define SPSEL_C_DIV 8'h82
`define SPSEL_C_WDOG 8'h83
`define SPSEL_C_CAL 8'h84
`define SPSEL_C_LOCK 8'h85
`define SPSEL_C_STABLE 8'h86
`define SPSEL_C_ALL_LOCK 8'h87
`define SPSEL_C_LOOP0 8'h88
`define SPSEL_C_MEM_WR 8'h8C
`define SPSEL_C_MEM_RD 8'h8D
`define SPSEL_C_MEM_FLT 8'h8E
`define SPSEL_C_IRQ_ALL 8'h90
`define SPSEL_C_IRQ_COM 8'h91
`define SPSEL_C_IRQ_L0 8'h92
`define SPSEL_C_FLT_A 8'hA0
`define SPSEL_C_VAL_A 8'hA8
`define SPSEL_C_ACT_A 8'hB0
`define SPSEL_C_ACT_C 8'hB2

// =====================================================================
// Status bit positions and timing
`define SPSEL_LOOP_LOCK_BIT 0
`define SPSEL_LOOP_STABLE_BIT 1
`define SPSEL_LOOP_CAL_BIT 2
`define SPSEL_LOOP_COMB_LSB 4
`define SPSEL_REF_FAULT_BIT 2
`define SPSEL_REF_VALID_BIT 3
`define SPSEL_REF_ACT_LSB 4
`define SPSEL_MEM_WR_BIT 0
`define SPSEL_MEM_RD_BIT 1
`define SPSEL_MEM_FLT_BIT 2
`define SPSEL_DIV_RATIO 32
`define SPSEL_STROBE_CYCLES 32
`endif

/* design/spsel_pkg.sv */
package spsel_pkg;
   typedef struct packed {
      logic [3:0] ref_act;
      logic valid;
      logic fault;
   } spsel_ref_type;

   typedef struct packed {
      logic [3:0] loop_irq;
      logic common_irq;
   } spsel_irq_type;

   typedef struct packed {
      logic [3:0] digital_lock;
      logic [3:0] analog_lock;
      logic lock;
      logic stable;
      logic cal_busy;
   } spsel_loop_type;

   typedef struct packed {
      logic fault;
      logic rd_busy;
      logic wr_busy;
   } spsel_mem_type;

   typedef enum logic [1:0] {
      SPSEL_WD_IDLE = 2'b00,
      SPSEL_WD_STROBE = 2'b01
   } spsel_wd_state_type;
endpackage

/* design/spsel_strobe.sv */
`timescale 1ns/1ps
`include "spsel_map.svh"
// =====================================================================
// Watchdog strobe stretcher and clock divider
module spsel_strobe (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic expire,
   output logic strobe,
   output logic div_clk
);
   import spsel_pkg::*;

   spsel_wd_state_type state_q;
   logic [4:0] cnt_q;
   logic [3:0] div_q;

   // A second expiry during a strobe is absorbed: the pulse width stays fixed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SPSEL_WD_IDLE;
         cnt_q <= 5'h00;
      end else if (clk_en) begin
         unique case (state_q)
            SPSEL_WD_IDLE: begin
               if (expire) begin
                  state_q <= SPSEL_WD_STROBE;
                  cnt_q <= 5'(`SPSEL_STROBE_CYCLES - 1);
               end
            end
            SPSEL_WD_STROBE: begin
               if (cnt_q == 5'h00) begin
                  state_q <= SPSEL_WD_IDLE;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            default: state_q <= SPSEL_WD_IDLE;
         endcase
      end
   end

   assign strobe = (state_q == SPSEL_WD_STROBE);

   // Helper count of strobe cycles, so that the full width is checked and not a prefix.
   logic [5:0] width_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         width_q <= 6'h00;
      end else if (clk_en) begin
         if (strobe) begin
            width_q <= width_q + 6'h01;
         end else begin
            width_q <= 6'h00;
         end
      end
   end

   chk_strobe_len: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(strobe) |-> width_q == 6'(`SPSEL_STROBE_CYCLES))
      else $error("watchdog strobe width wrong");

   // Toggle every 16 cycles gives a period of 32 system clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
         div_clk <= 1'b0;
      end else if (clk_en) begin
         div_q <= div_q + 4'h1;
         if (div_q == 4'(`SPSEL_DIV_RATIO / 2 - 1)) begin
            div_clk <= ~div_clk;
         end
      end
   end
endmodule

/* design/spsel_top.sv */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "spsel_map.svh"
// =====================================================================
// Status pin output selector with APB access
module spsel_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spsel_pkg::spsel_loop_type loop_in,
   input wire spsel_pkg::spsel_mem_type mem_in,
   input wire spsel_pkg::spsel_irq_type irq_in,
   input wire spsel_pkg::spsel_ref_type [3:0] ref_in,
   input wire logic watchdog_expire,
   output logic status_pin
);
   import spsel_pkg::*;

   // =====================================================================
   // Register file
   logic [7:0] func_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic pin_q;
   logic pin_d;
   logic strobe;
   logic div_clk;
   logic [3:0] loop_comb;
   logic [3:0] ref_fault;
   logic [3:0] ref_valid;
   logic [3:0] ref_active;
   logic access;
   logic mapped;
   logic [31:0] rd_d;

   assign access = psel && penable && !pready_q;

   always_comb begin
      rd_d = 32'h00000000;
      mapped = 1'b1;
      unique case (paddr)
         `SPSEL_FUNC_OFFSET: rd_d = {24'h000000, func_q};
         `SPSEL_MEM_OFFSET: rd_d = {29'h00000000, mem_in};
         `SPSEL_LOOP_OFFSET: rd_d = {24'h000000, loop_comb, 1'b0, loop_in.cal_busy,
                                     loop_in.stable, loop_in.lock};
         `SPSEL_REF_OFFSET: rd_d = {20'h00000, ref_active, ref_valid, ref_fault};
         `SPSEL_IRQ_OFFSET: rd_d = {27'h0000000, irq_in};
         `SPSEL_PIN_OFFSET: rd_d = {31'h00000000, pin_q};
         default: mapped = 1'b0;
      endcase
   end

   // One wait state: the answer comes on the second access-phase edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (clk_en) begin
         pready_q <= access;
         pslverr_q <= access && !mapped;
         if (access && !pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // Writes with the top bit clear are kept as well; such codes leave the pin low.
   // The write lands on the completing edge, where the master sees pready high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_q <= `SPSEL_FUNC_RESET;
      end else if (clk_en && psel && penable && pready_q && pwrite &&
                   paddr == `SPSEL_FUNC_OFFSET) begin
         func_q <= pwdata[7:0];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // =====================================================================
   // Status combinations
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_per
         assign loop_comb[gi] = loop_in.digital_lock[gi] && loop_in.analog_lock[gi] &&
                                loop_in.lock;
         assign ref_fault[gi] = ref_in[gi].fault;
         assign ref_valid[gi] = ref_in[gi].valid;
         assign ref_active[gi] = |ref_in[gi].ref_act;
      end
   endgenerate

   spsel_strobe u_strobe (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .expire(watchdog_expire),
      .strobe(strobe),
      .div_clk(div_clk)
   );

   // =====================================================================
   // Pin function selection
   always_comb begin
      pin_d = 1'b0;
      if (func_q[`SPSEL_TOP_BIT]) begin
         if (func_q >= `SPSEL_C_LOOP0 && func_q <= `SPSEL_C_LOOP0 + 8'h03) begin
            pin_d = loop_comb[func_q[1:0]];
         end else if (func_q >= `SPSEL_C_IRQ_L0 && func_q <= `SPSEL_C_IRQ_L0 + 8'h03) begin
            pin_d = irq_in.loop_irq[2'(func_q - `SPSEL_C_IRQ_L0)];
         end else if (func_q >= `SPSEL_C_FLT_A && func_q <= `SPSEL_C_FLT_A + 8'h03) begin
            pin_d = ref_fault[func_q[1:0]];
         end else if (func_q >= `SPSEL_C_VAL_A && func_q <= `SPSEL_C_VAL_A + 8'h03) begin
            pin_d = ref_valid[func_q[1:0]];
         end else if (func_q >= `SPSEL_C_ACT_A && func_q <= `SPSEL_C_ACT_C) begin
            pin_d = ref_active[func_q[1:0]];
         end else begin
            unique case (func_q)
               `SPSEL_C_LOW: pin_d = 1'b0;
               `SPSEL_C_HIGH: pin_d = 1'b1;
               `SPSEL_C_DIV: pin_d = div_clk;
               `SPSEL_C_WDOG: pin_d = strobe;
               `SPSEL_C_CAL: pin_d = loop_in.cal_busy;
               `SPSEL_C_LOCK: pin_d = loop_in.lock;
               `SPSEL_C_STABLE: pin_d = loop_in.stable;
               `SPSEL_C_ALL_LOCK: pin_d = &loop_comb;
               `SPSEL_C_MEM_WR: pin_d = mem_in.wr_busy;
               `SPSEL_C_MEM_RD: pin_d = mem_in.rd_busy;
               `SPSEL_C_MEM_FLT: pin_d = mem_in.fault;
               `SPSEL_C_IRQ_ALL: pin_d = irq_in.common_irq || |irq_in.loop_irq;
               `SPSEL_C_IRQ_COM: pin_d = irq_in.common_irq;
               default: pin_d = 1'b0;
            endcase
         end
      end
   end

   // The pin is registered, so every selection appears one cycle after its source.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
      end else if (clk_en) begin
         pin_q <= pin_d;
      end
   end

   assign status_pin = pin_q;

   // =====================================================================
   // Checks
   chk_static_high: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_HIGH ##1 clk_en |-> status_pin)
      else $error("pin not high for static one");
   chk_static_low: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_LOW |=> !status_pin)
      else $error("pin not low for static zero");
   chk_unassigned_low: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == 8'h8F |=> !status_pin)
      else $error("unassigned code drove pin");
   chk_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(strobe) && clk_en |-> strobe [*8])
      else $error("watchdog strobe too short");
   chk_all_lock: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_ALL_LOCK |=> status_pin == $past(&loop_comb))
      else $error("all lock mismatch");
   chk_lock_mirror: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_LOCK |=> status_pin == $past(loop_in.lock))
      else $error("lock mirror mismatch");
   chk_mem_write: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_MEM_WR |=> status_pin == $past(mem_in.wr_busy))
      else $error("memory write flag mismatch");
   chk_irq_any: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_IRQ_ALL && |irq_in |=> status_pin)
      else $error("interrupt OR not shown");
   chk_ref_valid: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && func_q == `SPSEL_C_VAL_A |=> status_pin == $past(ref_in[0].valid))
      else $error("reference valid mismatch");
   chk_div_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && $changed(div_clk) |=> !$changed(div_clk))
      else $error("divider toggled too fast");

   cov_strobe: cover property (@(posedge pclk) disable iff (!presetn)
      func_q == `SPSEL_C_WDOG && status_pin);
   cov_divided: cover property (@(posedge pclk) disable iff (!presetn)
      func_q == `SPSEL_C_DIV && $rose(status_pin));
   cov_ref_active: cover property (@(posedge pclk) disable iff (!presetn)
      func_q == `SPSEL_C_ACT_C && status_pin);
   cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

/* tb/spsel_pin_mon.sv */
`timescale 1ns/1ps
// =====================================================================
// Board-side monitor that measures how long the status pin stays high and low
module spsel_pin_mon (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic status_pin,
   output logic [7:0] hi_len,
   output logic [7:0] lo_len
);
   logic [7:0] run_q;
   logic last_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 8'h01;
         last_q <= 1'b0;
         hi_len <= 8'h00;
         lo_len <= 8'h00;
      end else begin
         last_q <= status_pin;
         if (status_pin == last_q) begin
            run_q <= run_q + 8'h01;
         end else begin
            run_q <= 8'h01;
            if (last_q) begin
               hi_len <= run_q;
            end else begin
               lo_len <= run_q;
            end
         end
      end
   end
endmodule

/* tb/spsel_top_tb_top.sv */
`timescale 1ns/1ps
module spsel_top_tb_top;
   import spsel_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic clk_en = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, er, status_pin, watchdog_expire = 1'b0;
   spsel_loop_type loop_in = '0;
   spsel_mem_type mem_in = '0;
   spsel_irq_type irq_in = '0;
   spsel_ref_type [3:0] ref_in = '0;
   logic [7:0] hi_len, lo_len;
   int n_errors = 0, n_checks = 0, cyc = 0;
   logic [42:0] pats [4] = '{43'h0, '1, 43'h555_5555_5555, 43'h2AA_AAAA_AAAA};
   always #12.5 pclk = ~pclk;
   spsel_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .loop_in(loop_in), .mem_in(mem_in),
      .irq_in(irq_in), .ref_in(ref_in), .watchdog_expire(watchdog_expire),
      .status_pin(status_pin));
   spsel_pin_mon mon_u (.pclk(pclk), .presetn(presetn), .status_pin(status_pin),
      .hi_len(hi_len), .lo_len(lo_len));
   // =====================================================================
   // Shared tasks
   task stop_test;
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("wait states", k, 32'h2);
   endtask
   // The expected pin level is worked out here from the function code and the input pattern alone.
   function automatic logic expv(input logic [7:0] c, input logic [42:0] p);
      spsel_loop_type l;
      spsel_mem_type m;
      spsel_irq_type q;
      spsel_ref_type [3:0] r;
      logic [3:0] comb;
      logic [7:0] qi;
      {l, m, q, r} = p;
      comb = l.digital_lock & l.analog_lock & {4{l.lock}};
      qi = c - 8'h92;
      case (c) inside
         8'h81: expv = 1'b1;
         8'h84: expv = l.cal_busy;
         8'h85: expv = l.lock;
         8'h86: expv = l.stable;
         8'h87: expv = &comb;
         [8'h88:8'h8B]: expv = comb[c[1:0]];
         8'h8C: expv = m.wr_busy;
         8'h8D: expv = m.rd_busy;
         8'h8E: expv = m.fault;
         8'h90: expv = |q;
         8'h91: expv = q.common_irq;
         [8'h92:8'h95]: expv = q.loop_irq[qi[1:0]];
         [8'hA0:8'hA3]: expv = r[c[1:0]].fault;
         [8'hA8:8'hAB]: expv = r[c[1:0]].valid;
         [8'hB0:8'hB2]: expv = |r[c[1:0]].ref_act;
         default: expv = 1'b0;
      endcase
   endfunction
   task expire_pulse;
      @(posedge pclk);
      watchdog_expire <= 1'b1;
      @(posedge pclk);
      watchdog_expire <= 1'b0;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         stop_test;
      end
   end
   // =====================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("func reset", rd, 32'h80);
      apb(1'b1, 12'h000, 32'h81);
      apb(1'b0, 12'h014, 32'h0);
      chk("pin reg", rd, 32'h1);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (int c = 8'h7E; c < 8'hC0; c++) begin
         if (c == 8'h82 || c == 8'h83) continue;
         apb(1'b1, 12'h000, c);
         foreach (pats[i]) begin
            @(posedge pclk);
            {loop_in, mem_in, irq_in, ref_in} <= pats[i];
            repeat (3) @(posedge pclk);
            #1 chk("pin", status_pin, expv(c[7:0], pats[i]));
         end
      end
      @(posedge pclk);
      {loop_in, mem_in, irq_in, ref_in} <= pats[2];
      apb(1'b0, 12'h004, 32'h0);
      chk("mem reg", rd, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk("loop reg", rd, 32'hA5);
      apb(1'b0, 12'h00C, 32'h0);
      chk("ref reg", rd, 32'hF0F);
      apb(1'b0, 12'h010, 32'h0);
      chk("irq reg", rd, 32'h15);
      // With the clock enable low the pin must hold although its source moves.
      apb(1'b1, 12'h000, 32'h85);
      @(posedge pclk);
      loop_in.lock <= 1'b1;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b0;
      loop_in.lock <= 1'b0;
      repeat (4) @(posedge pclk);
      #1 chk("frozen pin", status_pin, 32'h1);
      @(posedge pclk);
      clk_en <= 1'b1;
      repeat (3) @(posedge pclk);
      #1 chk("released pin", status_pin, 32'h0);
      apb(1'b1, 12'h000, 32'h82);
      repeat (100) @(posedge pclk);
      chk("div high", hi_len, 32'h10);
      chk("div low", lo_len, 32'h10);
      // A second expiry inside the strobe must not stretch it.
      apb(1'b1, 12'h000, 32'h83);
      repeat (20) @(posedge pclk);
      expire_pulse;
      repeat (10) @(posedge pclk);
      expire_pulse;
      repeat (60) @(posedge pclk);
      chk("strobe", hi_len, 32'h20);
      stop_test;
   end
endmodule
